// File: design/pfd_pkg.sv
/*
 * Package for the partition feature page decoder: page geometry, register offsets,
 * region classes and the access carrier structs.
 * Assumes one clock domain and a register bus modelled as plain ports.
 */
package pfd_pkg;

	// page geometry
	localparam int unsigned PAGE_ALIGN_BITS = 12;           // 4 KB base alignment
	localparam int unsigned BLOCK_BITS      = 16;           // 64 KB containing block
	localparam logic [15:0] MAX_OFS_FULL    = 16'h3fff;     // impl region tops out here
	localparam logic [15:0] MAX_OFS_NO_BW   = 16'h1fff;     // without bandwidth bitmap
	localparam logic [15:0] MAX_OFS_NO_BMP  = 16'h0fff;     // without either bitmap
	localparam logic [15:0] IMPL_BASE       = 16'h3000;     // implementation region start

	// register offsets
	localparam logic [15:0] OFS_MAIN_ID   = 16'h0000;
	localparam logic [15:0] OFS_SEC_ID    = 16'h0008;
	localparam logic [15:0] OFS_IMPL_ID   = 16'h0018;
	localparam logic [15:0] OFS_ARCH_VER  = 16'h0020;
	localparam logic [15:0] OFS_MON_ID    = 16'h0080;
	localparam logic [15:0] OFS_ERR_CTL   = 16'h00f0;
	localparam logic [15:0] OFS_ERR_STAT  = 16'h00f8;
	localparam logic [15:0] OFS_PART_SEL  = 16'h0100;
	localparam logic [15:0] OFS_MON_SEL   = 16'h0800;
	localparam logic [15:0] OFS_CACHE_BMP = 16'h1000;
	localparam logic [15:0] OFS_BW_BMP    = 16'h2000;

	// bitmap range extents in bytes
	localparam logic [15:0] CACHE_BMP_SPAN = 16'h1000;
	localparam logic [15:0] BW_BMP_SPAN    = 16'h1000;

	// register reset values
	localparam logic [31:0] RST_ERR_CTL  = 32'h0000_0000;
	localparam logic [31:0] RST_ERR_STAT = 32'h0000_0000;
	localparam logic [31:0] RST_PART_SEL = 32'h0000_0000;
	localparam logic [31:0] RST_MON_SEL  = 32'h0000_0000;

	// decoded target of one access
	typedef enum logic [3:0] {
		PFD_T_RSVD     = 4'h0,
		PFD_T_MAIN_ID  = 4'h1,
		PFD_T_SEC_ID   = 4'h2,
		PFD_T_IMPL_ID  = 4'h3,
		PFD_T_ARCH_VER = 4'h4,
		PFD_T_MON_ID   = 4'h5,
		PFD_T_ERR_CTL  = 4'h6,
		PFD_T_ERR_STAT = 4'h7,
		PFD_T_PART_SEL = 4'h8,
		PFD_T_MON_SEL  = 4'h9,
		PFD_T_CBMP     = 4'ha,
		PFD_T_BBMP     = 4'hb,
		PFD_T_IMPL     = 4'hc
	} pfd_target_t;

	// request from the bus side
	typedef struct packed {
		logic        valid;
		logic        write;
		logic        nonsec;   // nonsecure_attribute of the access
		logic [31:0] addr;
		logic [31:0] wdata;
	} pfd_req_t;

	// answer to the bus side
	typedef struct packed {
		logic        valid;
		logic        reserved; // access was read_zero_write_ignored
		logic [31:0] rdata;
	} pfd_rsp_t;

endpackage : pfd_pkg

// File: design/pfd_decode.sv
/*
 * Feature page decoder with the Secure/Non-secure banking of the shared registers.
 * Assumes the bus presents one 32-bit access per cycle on plain ports, synchronous
 * to CLK_SYS; per-register contents beyond selection and error words live outside.
 */
`timescale 1ns/100ps
module pfd_decode #(
	parameter logic [31:0] NS_BASE     = 32'h0001_0000,  // non-secure page base
	parameter logic [31:0] S_BASE      = 32'h0002_0000,  // secure page base
	parameter bit          HAS_SECURE  = 1'b1,           // secure accesses supported
	parameter bit          HAS_CTRL    = 1'b1,           // any resource control
	parameter bit          HAS_MON     = 1'b1,           // any resource monitor
	parameter bit          HAS_ERR     = 1'b1,           // error detection
	parameter int unsigned PART_W      = 16,             // partition_identifier width
	parameter int unsigned MON_W       = 16,             // monitor index width
	parameter int unsigned CBMP_BYTES  = 16'h0080,       // implemented cache bitmap bytes
	parameter int unsigned BBMP_BYTES  = 16'h0080        // implemented bandwidth bitmap bytes
) (
	input  wire logic             CLK_SYS,               // 25 MHz system clock
	input  wire logic             NRST,                  // async reset, active low
	input  wire pfd_pkg::pfd_req_t REQ,                  // bus access
	output pfd_pkg::pfd_rsp_t      RSP,                  // registered answer
	input  wire logic             CACHE_PORTION_PRESENT, // cache_portion_present
	input  wire logic             BW_PART_PRESENT,       // bandwidth_partitioning_present
	input  wire logic             BW_BITMAP_PRESENT,     // bandwidth_bitmap_present
	input  wire logic [31:0]      MAIN_ID_NS,            // main_feature_id_reg, non-secure
	input  wire logic [31:0]      MAIN_ID_S,             // main_feature_id_reg, secure
	input  wire logic [31:0]      SEC_ID,                // secure_identification_reg
	input  wire logic [31:0]      IMPL_ID,               // implementation_identification_reg
	input  wire logic [31:0]      ARCH_VER,              // architecture_version_reg
	input  wire logic [31:0]      MON_ID,                // monitor_identification_reg (shared)
	input  wire logic             ERR_EVENT,             // hardware error seen
	input  wire logic             ERR_EVENT_NS,          // error belongs to non-secure space
	input  wire logic [31:0]      ERR_CODE,              // error status word to record
	input  wire logic [31:0]      CBMP_RDATA,            // cache bitmap read data
	input  wire logic [31:0]      BBMP_RDATA,            // bandwidth bitmap read data
	input  wire logic [31:0]      IMPL_RDATA,            // implementation region read data
	output logic                  CFG_WE,                // bitmap or impl write strobe
	output logic                  CFG_NS,                // copy that the write targets
	output logic [15:0]           CFG_OFS,               // page offset of the write
	output logic [31:0]           CFG_WDATA,             // write data
	output logic [PART_W-1:0]     PART_SEL_NS,           // non-secure partition selection
	output logic [PART_W-1:0]     PART_SEL_S,            // secure partition selection
	output logic [MON_W-1:0]      MON_SEL_NS,            // non-secure monitor selection
	output logic [MON_W-1:0]      MON_SEL_S,             // secure monitor selection
	output logic [31:0]           ERR_CTL_NS,            // non-secure error control
	output logic [31:0]           ERR_CTL_S              // secure error control
);
	import pfd_pkg::*;

	// banked state: index 0 secure, index 1 non-secure
	logic [31:0] part_sel [2];
	logic [31:0] mon_sel  [2];
	logic [31:0] err_ctl  [2];
	logic [31:0] err_stat [2];
	logic [31:0] next_part_sel [2];
	logic [31:0] next_mon_sel  [2];
	logic [31:0] next_err_ctl  [2];
	logic [31:0] next_err_stat [2];
	pfd_rsp_t    next_rsp;
	logic        next_cfg_we;
	logic        next_cfg_ns;
	logic [15:0] next_cfg_ofs;
	logic [31:0] next_cfg_wdata;

	logic        hit;
	logic        bank;
	logic [15:0] ofs;
	logic [15:0] max_ofs;
	pfd_target_t tgt;
	logic        ro_tgt;
	logic        rsvd;

	initial begin
		if (NS_BASE[PAGE_ALIGN_BITS-1:0] != '0 || S_BASE[PAGE_ALIGN_BITS-1:0] != '0)
			$error("feature page base not 4 KB aligned");
		if (NS_BASE[BLOCK_BITS-1:0] > 32'(16'hffff - MAX_OFS_FULL) ||
			S_BASE[BLOCK_BITS-1:0] > 32'(16'hffff - MAX_OFS_FULL))
			$error("feature page crosses a 64 KB block");
	end

	// security attribute picks page and bank
	always_comb begin
		bank = REQ.nonsec;
		ofs  = '0;
		hit  = 1'b0;
		// secure page only when secure accesses are supported
		if (REQ.nonsec && REQ.addr[31:BLOCK_BITS] == NS_BASE[31:BLOCK_BITS] &&
			REQ.addr[BLOCK_BITS-1:0] >= NS_BASE[BLOCK_BITS-1:0]) begin
			ofs = 16'(REQ.addr[BLOCK_BITS-1:0] - NS_BASE[BLOCK_BITS-1:0]);
			hit = 1'b1;
		end else if (!REQ.nonsec && HAS_SECURE && REQ.addr[31:BLOCK_BITS] == S_BASE[31:BLOCK_BITS] &&
			REQ.addr[BLOCK_BITS-1:0] >= S_BASE[BLOCK_BITS-1:0]) begin
			ofs = 16'(REQ.addr[BLOCK_BITS-1:0] - S_BASE[BLOCK_BITS-1:0]);
			hit = 1'b1;
		end
	end

	always_comb begin
		if (!(BW_PART_PRESENT && BW_BITMAP_PRESENT) && !CACHE_PORTION_PRESENT)
			max_ofs = MAX_OFS_NO_BMP;
		else if (!(BW_PART_PRESENT && BW_BITMAP_PRESENT))
			max_ofs = MAX_OFS_NO_BW;
		else
			max_ofs = MAX_OFS_FULL;
	end

	// one word per access
	// a 32-bit access is one access; 64-bit registers expose only their low word
	always_comb begin
		tgt    = PFD_T_RSVD;
		ro_tgt = 1'b0;
		if (hit && ofs[1:0] == 2'b00) begin
			// implementation region from its base to the page end
			// offsets past the page end would otherwise alias into it
			if (ofs >= IMPL_BASE && ofs <= MAX_OFS_FULL) begin
				tgt = PFD_T_IMPL;
			// bitmap ranges limited to implemented width
			end else if (ofs >= OFS_BW_BMP && ofs < 16'(OFS_BW_BMP + BW_BMP_SPAN)) begin
				if (BW_PART_PRESENT && BW_BITMAP_PRESENT && ofs - OFS_BW_BMP < 16'(BBMP_BYTES))
					tgt = PFD_T_BBMP;
			end else if (ofs >= OFS_CACHE_BMP && ofs < 16'(OFS_CACHE_BMP + CACHE_BMP_SPAN)) begin
				if (CACHE_PORTION_PRESENT && ofs - OFS_CACHE_BMP < 16'(CBMP_BYTES))
					tgt = PFD_T_CBMP;
			end else begin
				// anything not listed falls to reserved
				case (ofs)
					OFS_MAIN_ID: begin
						tgt    = PFD_T_MAIN_ID;
						ro_tgt = 1'b1;
					end
					// secure id only from secure space
					OFS_SEC_ID: begin
						tgt    = bank ? PFD_T_RSVD : PFD_T_SEC_ID;
						ro_tgt = 1'b1;
					end
					OFS_IMPL_ID: begin
						tgt    = PFD_T_IMPL_ID;
						ro_tgt = 1'b1;
					end
					OFS_ARCH_VER: begin
						tgt    = PFD_T_ARCH_VER;
						ro_tgt = 1'b1;
					end
					// monitor id and selection with monitors
					OFS_MON_ID: begin
						tgt    = HAS_MON ? PFD_T_MON_ID : PFD_T_RSVD;
						ro_tgt = 1'b1;
					end
					OFS_MON_SEL:  tgt = HAS_MON ? PFD_T_MON_SEL : PFD_T_RSVD;
					OFS_ERR_CTL:  tgt = HAS_ERR ? PFD_T_ERR_CTL : PFD_T_RSVD;
					OFS_ERR_STAT: tgt = HAS_ERR ? PFD_T_ERR_STAT : PFD_T_RSVD;
					OFS_PART_SEL: tgt = HAS_CTRL ? PFD_T_PART_SEL : PFD_T_RSVD;
					default:      tgt = PFD_T_RSVD;
				endcase
			end
			// beyond the truncated end only the implementation region is decoded
			if (ofs > max_ofs && tgt != PFD_T_IMPL)
				tgt = PFD_T_RSVD;
		end
	end

	// write to a read-only location is reserved
	assign rsvd = (tgt == PFD_T_RSVD) || (REQ.write && ro_tgt);

	// register next values; hardware error set wins over software write
	always_comb begin
		next_part_sel = part_sel;
		next_mon_sel  = mon_sel;
		next_err_ctl  = err_ctl;
		next_err_stat = err_stat;
		next_rsp      = '0;
		next_cfg_we    = 1'b0;
		next_cfg_ns    = bank;
		next_cfg_ofs   = ofs;
		next_cfg_wdata = REQ.wdata;
		if (REQ.valid) begin
			next_rsp.valid    = 1'b1;
			next_rsp.reserved = rsvd;
			if (!rsvd && REQ.write) begin
				case (tgt)
					PFD_T_PART_SEL: next_part_sel[bank] = 32'(REQ.wdata[PART_W-1:0]);
					PFD_T_MON_SEL:  next_mon_sel[bank]  = 32'(REQ.wdata[MON_W-1:0]);
					PFD_T_ERR_CTL:  next_err_ctl[bank]  = REQ.wdata;
					PFD_T_ERR_STAT: next_err_stat[bank] = REQ.wdata;
					PFD_T_CBMP, PFD_T_BBMP, PFD_T_IMPL: next_cfg_we = 1'b1;
					default:        next_cfg_we = 1'b0;
				endcase
			end else if (!rsvd) begin
				case (tgt)
					// main id banked, monitor id shared
					PFD_T_MAIN_ID:  next_rsp.rdata = bank ? MAIN_ID_NS : MAIN_ID_S;
					PFD_T_SEC_ID:   next_rsp.rdata = SEC_ID;
					PFD_T_IMPL_ID:  next_rsp.rdata = IMPL_ID;
					PFD_T_ARCH_VER: next_rsp.rdata = ARCH_VER;
					PFD_T_MON_ID:   next_rsp.rdata = MON_ID;
					PFD_T_PART_SEL: next_rsp.rdata = part_sel[bank];
					PFD_T_MON_SEL:  next_rsp.rdata = mon_sel[bank];
					PFD_T_ERR_CTL:  next_rsp.rdata = err_ctl[bank];
					PFD_T_ERR_STAT: next_rsp.rdata = err_stat[bank];
					PFD_T_CBMP:     next_rsp.rdata = CBMP_RDATA;
					PFD_T_BBMP:     next_rsp.rdata = BBMP_RDATA;
					PFD_T_IMPL:     next_rsp.rdata = IMPL_RDATA;
					default:        next_rsp.rdata = '0;
				endcase
			end
		end
		// errors recorded in their own space's copy
		if (HAS_ERR && ERR_EVENT && (ERR_EVENT_NS || HAS_SECURE))
			next_err_stat[ERR_EVENT_NS] = ERR_CODE;
	end

	// registers
	always_ff @(posedge CLK_SYS or negedge NRST) begin
		if (!NRST) begin
			part_sel  <= '{RST_PART_SEL, RST_PART_SEL};
			mon_sel   <= '{RST_MON_SEL, RST_MON_SEL};
			err_ctl   <= '{RST_ERR_CTL, RST_ERR_CTL};
			err_stat  <= '{RST_ERR_STAT, RST_ERR_STAT};
			RSP       <= '0;
			CFG_WE    <= 1'b0;
			CFG_NS    <= 1'b0;
			CFG_OFS   <= '0;
			CFG_WDATA <= '0;
		end else begin
			part_sel  <= next_part_sel;
			mon_sel   <= next_mon_sel;
			err_ctl   <= next_err_ctl;
			err_stat  <= next_err_stat;
			RSP       <= next_rsp;
			CFG_WE    <= next_cfg_we;
			CFG_NS    <= next_cfg_ns;
			CFG_OFS   <= next_cfg_ofs;
			CFG_WDATA <= next_cfg_wdata;
		end
	end

	assign PART_SEL_S  = part_sel[0][PART_W-1:0];
	assign PART_SEL_NS = part_sel[1][PART_W-1:0];
	assign MON_SEL_S   = mon_sel[0][MON_W-1:0];
	assign MON_SEL_NS  = mon_sel[1][MON_W-1:0];
	assign ERR_CTL_S   = err_ctl[0];
	assign ERR_CTL_NS  = err_ctl[1];

	// checks
	a_rsvd_reads_zero: assert property (@(posedge CLK_SYS) disable iff (!NRST)
		REQ.valid && rsvd |=> RSP.valid && RSP.reserved && RSP.rdata == 32'h0)
		else $error("reserved access returned data");
	a_sec_id_hidden: assert property (@(posedge CLK_SYS) disable iff (!NRST)
		REQ.valid && REQ.nonsec && hit && ofs == OFS_SEC_ID |=> RSP.reserved)
		else $error("secure id visible to non-secure");
	a_rsvd_no_write: assert property (@(posedge CLK_SYS) disable iff (!NRST)
		REQ.valid && REQ.write && rsvd |=> !CFG_WE)
		else $error("reserved write had an effect");
	a_ro_write_rsvd: assert property (@(posedge CLK_SYS) disable iff (!NRST)
		REQ.valid && REQ.write && hit && ofs == OFS_MAIN_ID |=> RSP.reserved)
		else $error("write to read-only accepted");
	a_bank_isolated: assert property (@(posedge CLK_SYS) disable iff (!NRST)
		REQ.valid && REQ.write && REQ.nonsec |=> $stable(part_sel[0]) && $stable(mon_sel[0]))
		else $error("non-secure write reached secure copy");
	a_trunc_end: assert property (@(posedge CLK_SYS) disable iff (!NRST)
		REQ.valid && hit && !CACHE_PORTION_PRESENT && !BW_PART_PRESENT && ofs > MAX_OFS_NO_BMP &&
		ofs < IMPL_BASE |=> RSP.reserved)
		else $error("access past truncated page end decoded");
	a_impl_region: assert property (@(posedge CLK_SYS) disable iff (!NRST)
		tgt == PFD_T_IMPL |-> ofs >= IMPL_BASE && ofs <= MAX_OFS_FULL)
		else $error("implementation region outside its range");
	a_past_page_end: assert property (@(posedge CLK_SYS) disable iff (!NRST)
		REQ.valid && hit && ofs > MAX_OFS_FULL |=> RSP.reserved && !CFG_WE)
		else $error("access past the page end decoded");
	a_err_set_wins: assert property (@(posedge CLK_SYS) disable iff (!NRST)
		HAS_ERR && ERR_EVENT && ERR_EVENT_NS |=> err_stat[1] == $past(ERR_CODE))
		else $error("hardware error lost to a software write");
	a_same_arch: assert property (@(posedge CLK_SYS) disable iff (!NRST)
		REQ.valid && !REQ.write && hit && ofs == OFS_ARCH_VER |=> RSP.rdata == $past(ARCH_VER))
		else $error("architecture version differs by page");
	c_sec_read: cover property (@(posedge CLK_SYS) REQ.valid && !REQ.nonsec && tgt == PFD_T_SEC_ID);
	c_sel_write: cover property (@(posedge CLK_SYS) REQ.valid && REQ.write && tgt == PFD_T_PART_SEL);
	c_bmp_write: cover property (@(posedge CLK_SYS) REQ.valid && REQ.write && tgt == PFD_T_CBMP);
	c_rsvd_hit: cover property (@(posedge CLK_SYS) REQ.valid && rsvd);

endmodule : pfd_decode

// File: tb/pfd_decode_tb.sv
/* Self-checking bench for the feature page decoder: directed and seeded random accesses
   checked against a bench model of both banks. Assumes default page geometry, one clock. */
`timescale 1ns/100ps
module pfd_decode_tb;
	import pfd_pkg::*;
	localparam logic [31:0] nsb       = 32'h0001_0000; // non-secure page base
	localparam logic [31:0] sb        = 32'h0002_0000; // secure page base
	localparam int unsigned bmp_bytes = 'h80;          // implemented bitmap bytes
	logic        clk_sys = 1'b0;
	logic        nrst    = 1'b0;
	pfd_req_t    req     = '0;
	pfd_rsp_t    rsp;
	logic        cpor = 1'b1, bwp = 1'b1, bwb = 1'b1, err_ev = 1'b0, err_ns = 1'b0;
	logic [31:0] id_ns = '0, id_s = '0, sid = '0, iid = '0, aver = '0, mid = '0, ecode = '0;
	logic [31:0] cbd = '0, bbd = '0, imd = '0, cfg_wd, ec_ns, ec_s;
	logic        cfg_we, cfg_ns;
	logic [15:0] cfg_ofs, ps_ns, ps_s, ms_ns, ms_s;
	logic [15:0] m_ps[2], m_ms[2];                     // bench copies, index is the attribute
	logic [31:0] m_ec[2], m_es[2];
	logic [15:0] tbl[24] = '{16'h0000, 16'h0004, 16'h0008, 16'h0018, 16'h0020, 16'h0080, 16'h00f0,
		16'h00f8, 16'h00fc, 16'h0100, 16'h0104, 16'h0800, 16'h1ffc, 16'h1000, 16'h107c, 16'h1080,
		16'h2000, 16'h207c, 16'h2080, 16'h3000, 16'h3ffc, 16'h4000, 16'h0024, 16'h0ffc};
	int          n_mismatch = 0;
	int          num_checks = 0;
	int          seed       = 32'ha8b7;

	// free-running 25 MHz clock
	always #20 clk_sys = ~clk_sys;

	pfd_decode #(.NS_BASE(nsb), .S_BASE(sb), .CBMP_BYTES(bmp_bytes), .BBMP_BYTES(bmp_bytes)) DUT (
		.CLK_SYS(clk_sys), .NRST(nrst), .REQ(req), .RSP(rsp),
		.CACHE_PORTION_PRESENT(cpor), .BW_PART_PRESENT(bwp), .BW_BITMAP_PRESENT(bwb),
		.MAIN_ID_NS(id_ns), .MAIN_ID_S(id_s), .SEC_ID(sid), .IMPL_ID(iid), .ARCH_VER(aver),
		.MON_ID(mid), .ERR_EVENT(err_ev), .ERR_EVENT_NS(err_ns), .ERR_CODE(ecode),
		.CBMP_RDATA(cbd), .BBMP_RDATA(bbd), .IMPL_RDATA(imd), .CFG_WE(cfg_we), .CFG_NS(cfg_ns),
		.CFG_OFS(cfg_ofs), .CFG_WDATA(cfg_wd), .PART_SEL_NS(ps_ns), .PART_SEL_S(ps_s),
		.MON_SEL_NS(ms_ns), .MON_SEL_S(ms_s), .ERR_CTL_NS(ec_ns), .ERR_CTL_S(ec_s));

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		num_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask : chk

	// expected {config strobe, reserved, read data}; walls off wrong page, attribute and truncation
	function automatic logic [33:0] model(input logic w, input logic ns, input logic [31:0] a);
		logic [15:0] o;
		logic [31:0] d;
		logic        ok;
		logic        cw;
		o = a[15:0];
		{ok, cw, d} = '0;
		if (a[31:16] == (ns ? nsb[31:16] : sb[31:16]) && o < 16'h4000 && a[1:0] == 2'b00)
			case (o)
				OFS_MAIN_ID:  {ok, d} = {!w, ns ? id_ns : id_s};
				OFS_SEC_ID:   {ok, d} = {!w && !ns, sid};
				OFS_IMPL_ID:  {ok, d} = {!w, iid};
				OFS_ARCH_VER: {ok, d} = {!w, aver};
				OFS_MON_ID:   {ok, d} = {!w, mid};
				OFS_ERR_CTL:  {ok, d} = {1'b1, m_ec[ns]};
				OFS_ERR_STAT: {ok, d} = {1'b1, m_es[ns]};
				OFS_PART_SEL: {ok, d} = {1'b1, 16'h0, m_ps[ns]};
				OFS_MON_SEL:  {ok, d} = {1'b1, 16'h0, m_ms[ns]};
				default:
					if (o >= IMPL_BASE)
						{ok, d, cw} = {1'b1, imd, w};
					else if (o >= OFS_BW_BMP && o < OFS_BW_BMP + bmp_bytes[15:0] && bwp && bwb)
						{ok, d, cw} = {1'b1, bbd, w};
					else if (o >= OFS_CACHE_BMP && o < OFS_CACHE_BMP + bmp_bytes[15:0] && cpor)
						{ok, d, cw} = {1'b1, cbd, w};
			endcase
		return {cw, !ok, (ok && !w) ? d : 32'h0};
	endfunction : model

	// one access, back to back with the next; answer checked one edge later
	task automatic go(input logic w, input logic ns, input logic [31:0] a, input logic [31:0] d);
		logic [33:0] e;
		{id_ns, id_s, sid} = {$random(seed), $random(seed), $random(seed)};
		{iid, aver, mid} = {$random(seed), $random(seed), $random(seed)};
		{cbd, bbd, imd} = {$random(seed), $random(seed), $random(seed)};
		e = model(w, ns, a);
		req = '{valid: 1'b1, write: w, nonsec: ns, addr: a, wdata: d};
		if (w && !e[32])
			case (a[15:0])
				OFS_ERR_CTL:  m_ec[ns] = d;
				OFS_ERR_STAT: m_es[ns] = d;
				OFS_PART_SEL: m_ps[ns] = d[15:0];
				OFS_MON_SEL:  m_ms[ns] = d[15:0];
				default: ;
			endcase
		@(posedge clk_sys);
		#1;
		chk({31'h0, rsp.valid}, 32'h1, "answer strobe");
		chk({31'h0, rsp.reserved}, {31'h0, e[32]}, "reserved flag");
		chk(rsp.rdata, e[31:0], "read data");
		chk({31'h0, cfg_we}, {31'h0, e[33]}, "config strobe");
		if (e[33]) begin
			chk({15'h0, cfg_ns, cfg_ofs}, {15'h0, ns, a[15:0]}, "config target");
			chk(cfg_wd, d, "config data");
		end
		chk({ps_ns, ps_s}, {m_ps[1], m_ps[0]}, "partition selection");
		chk({ms_ns, ms_s}, {m_ms[1], m_ms[0]}, "monitor selection");
		chk(ec_ns ^ ec_s, m_ec[1] ^ m_ec[0], "error control pair");
		chk(ec_ns, m_ec[1], "error control");
	endtask : go

	task automatic idle();
		req.valid = 1'b0;
		@(posedge clk_sys);
		#1;
		chk({31'h0, rsp.valid}, 32'h0, "idle strobe");
	endtask : idle

	// hardware error recorded into the bank named by its attribute
	task automatic hw_err(input logic ns, input logic [31:0] code);
		{err_ev, err_ns, ecode} = {1'b1, ns, code};
		m_es[ns] = code;
		idle();
		err_ev = 1'b0;
	endtask : hw_err

	task automatic rst();
		req.valid = 1'b0;
		nrst = 1'b0;
		m_ps = '{16'h0, 16'h0};
		m_ms = '{16'h0, 16'h0};
		m_ec = '{32'h0, 32'h0};
		m_es = '{32'h0, 32'h0};
		repeat (2) @(posedge clk_sys);
		#1;
		chk({ps_ns, ps_s} | {ms_ns, ms_s} | ec_ns | ec_s, 32'h0, "reset state");
		chk({30'h0, rsp.valid, cfg_we}, 32'h0, "reset strobes");
		nrst = 1'b1;
	endtask : rst

	task automatic close_out();
		$display("checks %0d, mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : close_out

	// watchdog, well past the roughly 600 cycles the sequence needs
	initial begin
		#(40 * 3000);
		n_mismatch++;
		close_out();
	end

	initial begin
		int i;
		int j;
		int r;
		rst();
		go(1'b1, 1'b1, nsb + 32'h100, 32'h0001_0005);
		go(1'b0, 1'b0, sb + 32'h100, 32'h0);
		go(1'b0, 1'b1, nsb + 32'h100, 32'h0);
		go(1'b0, 1'b0, sb + 32'h8, 32'h0);
		go(1'b0, 1'b1, nsb + 32'h8, 32'h0);
		go(1'b0, 1'b0, sb + 32'h0, 32'h0);
		go(1'b0, 1'b1, sb + 32'h0, 32'h0);
		go(1'b0, 1'b0, sb + 32'h18, 32'h0);
		go(1'b0, 1'b1, nsb + 32'h20, 32'h0);
		go(1'b1, 1'b0, sb + 32'h18, 32'h1);
		go(1'b1, 1'b1, nsb + 32'h0, 32'h1);
		go(1'b0, 1'b1, nsb + 32'h102, 32'h0);
		go(1'b1, 1'b0, sb + 32'h800, 32'h0000_0007);
		go(1'b1, 1'b1, nsb + 32'hf0, 32'h0000_0003);
		hw_err(1'b1, 32'h1234_0001);
		go(1'b0, 1'b1, nsb + 32'hf8, 32'h0);
		go(1'b0, 1'b0, sb + 32'hf8, 32'h0);
		// hardware error in the cycle of a software write: hardware wins
		{err_ev, err_ns, ecode} = {1'b1, 1'b1, 32'h00c0_0002};
		go(1'b1, 1'b1, nsb + 32'hf8, 32'h0000_0005);
		err_ev = 1'b0;
		m_es[1] = 32'h00c0_0002;
		go(1'b0, 1'b1, nsb + 32'hf8, 32'h0);
		go(1'b0, 1'b1, nsb + 32'hfc, 32'h0);
		idle();
		// truncation under every capability mix
		for (i = 0; i < 8; i++) begin
			{cpor, bwp, bwb} = i[2:0];
			for (j = 12; j < 21; j++)
				go(j[0], i[0], (i[0] ? nsb : sb) + {16'h0, tbl[j]}, 32'(i));
		end
		// reserved read data never steers later stimulus
		for (i = 0; i < 500; i++) begin
			if (i == 250)
				rst();
			if (i % 40 == 0)
				{cpor, bwp, bwb} = 3'($random(seed));
			r = $random(seed);
			j = $unsigned($random(seed)) % 24;
			go(r[8], r[9], ((r[3:0] == 4'h0) ^ r[9] ? nsb : sb) + {16'h0, tbl[j]} + ((r[7:4] == 4'h0) ? 32'h2 : 32'h0),
				$random(seed));
		end
		idle();
		close_out();
	end

endmodule : pfd_decode_tb
